// [tmr8_regs.vh]
// Constants for the 8-bit dual compare timer
`ifndef TMR8_REGS_VH
`define TMR8_REGS_VH
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hff
`define TMR8_CS_STOP 3'h0
`define TMR8_CS_DIRECT 3'h1
`define TMR8_CS_DIV8 3'h2
`define TMR8_CS_DIV64 3'h3
`define TMR8_CS_DIV256 3'h4
`define TMR8_CS_DIV1024 3'h5
`define TMR8_CS_EXT_FALL 3'h6
`define TMR8_CS_EXT_RISE 3'h7
`define TMR8_WGM_NORMAL 3'h0
`define TMR8_WGM_PC_MAX 3'h1
`define TMR8_WGM_CTC 3'h2
`define TMR8_WGM_FAST_MAX 3'h3
`define TMR8_WGM_PC_OCRA 3'h5
`define TMR8_WGM_FAST_OCRA 3'h7
`define TMR8_COM_NONE 2'h0
`define TMR8_COM_TOGGLE 2'h1
`define TMR8_COM_CLEAR 2'h2
`define TMR8_COM_SET 2'h3
`define TMR8_FLAG_OVF 0
`define TMR8_FLAG_MA 1
`define TMR8_FLAG_MB 2
`define TMR8_RST_CTRL 8'h00
`endif

// [tmr8_clksel.v]
// Timer clock selection: direct, prescaler taps and external edge detection
`timescale 1ns/1ps
`include "tmr8_regs.vh"
module tmr8_clksel (
    clk,
    rst,
    clock_select,
    presc_tap8,
    presc_tap64,
    presc_tap256,
    presc_tap1024,
    external_count_input,
    timer_clock
);
    input wire clk;
    input wire rst;
    input wire [2:0] clock_select;
    input wire presc_tap8;
    input wire presc_tap64;
    input wire presc_tap256;
    input wire presc_tap1024;
    input wire external_count_input;
    output reg timer_clock;

    reg ext_sync_ff;
    reg ext_cur_ff;
    reg ext_prev_ff;

    // ************************************************
    // External input sampling and edge history
    // ************************************************
    always @(posedge clk) begin
        if (rst) begin
            ext_sync_ff <= 1'b0;
            ext_cur_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
        end else begin
            // First stage feeds only the second; edges come from the later pair
            ext_sync_ff <= external_count_input;
            ext_cur_ff <= ext_sync_ff;
            ext_prev_ff <= ext_cur_ff;
        end
    end

    // ************************************************
    // Source multiplexer, one pulse per timer clock
    // ************************************************
    always @* begin
        case (clock_select)
            `TMR8_CS_STOP: timer_clock = 1'b0;
            `TMR8_CS_DIRECT: timer_clock = 1'b1;
            `TMR8_CS_DIV8: timer_clock = presc_tap8;
            `TMR8_CS_DIV64: timer_clock = presc_tap64;
            `TMR8_CS_DIV256: timer_clock = presc_tap256;
            `TMR8_CS_DIV1024: timer_clock = presc_tap1024;
            `TMR8_CS_EXT_FALL: timer_clock = ext_prev_ff & ~ext_cur_ff;
            default: timer_clock = ~ext_prev_ff & ext_cur_ff;
        endcase
    end
endmodule

// [tmr8_dual_compare.v]
// 8-bit up/down timer with two compare units, flags and pin override
`timescale 1ns/1ps
`include "tmr8_regs.vh"
// Function
// - Count 0x00 is bottom, 0xff is max; both drive waveform logic.
// - Top is 0xff or compare register A, depending on mode.
// - Counter and compare registers are 8 bits with 8-bit comparators.
// - Three-bit clock select; zero stops the counter.
// - Each timer clock clears, increments or decrements the counter.
// - Processor counter access anytime; writes beat clear or count.
// - Waveform mode: two low bits in control A, high bit in control B.
// - Overflow flag set at mode-defined point, can request interrupt.
// - Three flags in one register, each gated by its mask bit.
// - Equality sets the matching compare flag at the next timer clock.
// - Compare flag clears on service or on writing one.
// - Compare registers double-buffered in PWM modes only.
// - Buffered values load only at top or bottom.
// - Processor compare access hits buffer when buffered, else active. Here only writes do; COMPARE_VALUE_A/B always read the active value.
// - Force strobe in non-PWM modes acts on output only.
// - Counter write blocks every match in the next timer clock.
// - Output state bits survive waveform mode changes.
// - Output mode fields are unbuffered and act at once.
// - Reset clears the internal output state bits.
// - Nonzero output mode overrides port value; direction stays with port.
// - Output mode zero leaves output state unchanged on match.
// - Select one clocks directly; two to five use 8, 64, 256, 1024 taps.
// - Selects seven and six count rising and falling external edges.
module tmr8_dual_compare (
    SYS_CLK,
    SYS_RST,
    CLOCK_SELECT,
    WAVEFORM_MODE_LO,
    WAVEFORM_MODE_HI,
    COMPARE_OUTPUT_MODE_A,
    COMPARE_OUTPUT_MODE_B,
    FORCE_MATCH_STROBE_A,
    FORCE_MATCH_STROBE_B,
    PRESC_TAP8,
    PRESC_TAP64,
    PRESC_TAP256,
    PRESC_TAP1024,
    EXTERNAL_COUNT_INPUT,
    COUNT_WR,
    COUNT_WDATA,
    COMPARE_A_WR,
    COMPARE_B_WR,
    COMPARE_WDATA,
    FLAG_CLEAR_WR,
    FLAG_CLEAR_DATA,
    INT_ACK,
    TIMER_MASK_WR,
    TIMER_MASK_WDATA,
    PORT_VALUE_A,
    PORT_VALUE_B,
    COMPARE_PIN_DIRECTION_A,
    COMPARE_PIN_DIRECTION_B,
    COUNT_VALUE,
    COMPARE_VALUE_A,
    COMPARE_VALUE_B,
    TIMER_FLAG_REG,
    TIMER_MASK_REG,
    INT_REQ,
    AT_BOTTOM,
    AT_MAX,
    AT_TOP,
    COMPARE_OUT_A,
    COMPARE_OUT_B,
    PIN_OUT_A,
    PIN_OUT_B,
    PIN_OE_A,
    PIN_OE_B
);
    input wire SYS_CLK;
    input wire SYS_RST;
    input wire [2:0] CLOCK_SELECT;
    input wire [1:0] WAVEFORM_MODE_LO;
    input wire WAVEFORM_MODE_HI;
    input wire [1:0] COMPARE_OUTPUT_MODE_A;
    input wire [1:0] COMPARE_OUTPUT_MODE_B;
    input wire FORCE_MATCH_STROBE_A;
    input wire FORCE_MATCH_STROBE_B;
    input wire PRESC_TAP8;
    input wire PRESC_TAP64;
    input wire PRESC_TAP256;
    input wire PRESC_TAP1024;
    input wire EXTERNAL_COUNT_INPUT;
    input wire COUNT_WR;
    input wire [7:0] COUNT_WDATA;
    input wire COMPARE_A_WR;
    input wire COMPARE_B_WR;
    input wire [7:0] COMPARE_WDATA;
    input wire FLAG_CLEAR_WR;
    input wire [2:0] FLAG_CLEAR_DATA;
    input wire [2:0] INT_ACK;
    input wire TIMER_MASK_WR;
    input wire [2:0] TIMER_MASK_WDATA;
    input wire PORT_VALUE_A;
    input wire PORT_VALUE_B;
    input wire COMPARE_PIN_DIRECTION_A;
    input wire COMPARE_PIN_DIRECTION_B;
    output reg [7:0] COUNT_VALUE;
    output reg [7:0] COMPARE_VALUE_A;
    output reg [7:0] COMPARE_VALUE_B;
    output reg [2:0] TIMER_FLAG_REG;
    output reg [2:0] TIMER_MASK_REG;
    output reg INT_REQ;
    output reg AT_BOTTOM;
    output reg AT_MAX;
    output reg AT_TOP;
    output reg COMPARE_OUT_A;
    output reg COMPARE_OUT_B;
    output reg PIN_OUT_A;
    output reg PIN_OUT_B;
    output reg PIN_OE_A;
    output reg PIN_OE_B;

    // Compare output action on a match, shared by both units
    function cmp_action;
        input [1:0] mode;
        input cur;
        input pwm;
        input up;
        begin
            case (mode)
                `TMR8_COM_NONE: cmp_action = cur;
                `TMR8_COM_TOGGLE: cmp_action = ~cur;
                `TMR8_COM_CLEAR: cmp_action = pwm ? ~up : 1'b0;
                default: cmp_action = pwm ? up : 1'b1;
            endcase
        end
    endfunction

    // Output state at bottom in fast PWM: set for non-inverting, cleared for inverting
    function fast_bottom;
        input [1:0] mode;
        input cur;
        begin
            if (mode == `TMR8_COM_CLEAR) begin
                fast_bottom = 1'b1;
            end else if (mode == `TMR8_COM_SET) begin
                fast_bottom = 1'b0;
            end else begin
                fast_bottom = cur;
            end
        end
    endfunction

    wire timer_clock;
    wire [2:0] waveform_mode;
    reg [7:0] buf_a_ff;
    reg [7:0] buf_b_ff;
    reg down_ff;
    reg block_ff;
    reg oc_a_ff;
    reg oc_b_ff;
    reg [7:0] top_val;
    reg pwm_mode;
    reg fast_mode;
    reg pc_mode;
    reg at_top;
    reg match_a;
    reg match_b;
    reg [7:0] nxt_count;
    reg nxt_down;
    reg ovf_evt;
    reg nxt_oc_a;
    reg nxt_oc_b;
    reg load_buf;

    assign waveform_mode = {WAVEFORM_MODE_HI, WAVEFORM_MODE_LO};

    // ************************************************
    // Timer clock source
    // ************************************************
    tmr8_clksel u_clksel (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .clock_select(CLOCK_SELECT),
        .presc_tap8(PRESC_TAP8),
        .presc_tap64(PRESC_TAP64),
        .presc_tap256(PRESC_TAP256),
        .presc_tap1024(PRESC_TAP1024),
        .external_count_input(EXTERNAL_COUNT_INPUT),
        .timer_clock(timer_clock)
    );

    // ************************************************
    // Mode decode, top selection and comparators
    // ************************************************
    always @* begin
        fast_mode = (waveform_mode == `TMR8_WGM_FAST_MAX) ||
                    (waveform_mode == `TMR8_WGM_FAST_OCRA);
        pc_mode = (waveform_mode == `TMR8_WGM_PC_MAX) ||
                  (waveform_mode == `TMR8_WGM_PC_OCRA);
        pwm_mode = fast_mode | pc_mode;
        top_val = (waveform_mode == `TMR8_WGM_CTC || waveform_mode == `TMR8_WGM_PC_OCRA ||
                   waveform_mode == `TMR8_WGM_FAST_OCRA) ? COMPARE_VALUE_A : `TMR8_MAX;
        at_top = (COUNT_VALUE == top_val);
        match_a = (COUNT_VALUE == COMPARE_VALUE_A) & ~block_ff;
        match_b = (COUNT_VALUE == COMPARE_VALUE_B) & ~block_ff;
    end

    // ************************************************
    // Counter next state and waveform events
    // ************************************************
    always @* begin
        nxt_count = COUNT_VALUE;
        nxt_down = down_ff;
        ovf_evt = 1'b0;
        load_buf = 1'b0;
        nxt_oc_a = oc_a_ff;
        nxt_oc_b = oc_b_ff;
        if (timer_clock) begin
            if (pc_mode) begin
                if (at_top) begin
                    nxt_down = 1'b1;
                    load_buf = 1'b1;
                end else if (COUNT_VALUE == `TMR8_BOTTOM) begin
                    nxt_down = 1'b0;
                    ovf_evt = 1'b1;
                end
                nxt_count = (nxt_down ? COUNT_VALUE - 8'h01 : COUNT_VALUE + 8'h01);
            end else if (at_top) begin
                nxt_count = `TMR8_BOTTOM;
                ovf_evt = fast_mode | (COUNT_VALUE == `TMR8_MAX);
                load_buf = fast_mode;
                nxt_down = 1'b0;
            end else begin
                nxt_count = COUNT_VALUE + 8'h01;
                ovf_evt = ~fast_mode & (COUNT_VALUE == `TMR8_MAX);  // CTC past top
                nxt_down = 1'b0;
            end
            // Waveform update on match; mode switches never reset the state
            if (match_a) begin
                nxt_oc_a = cmp_action(COMPARE_OUTPUT_MODE_A, oc_a_ff, pc_mode, ~down_ff);
            end
            if (match_b) begin
                nxt_oc_b = cmp_action(COMPARE_OUTPUT_MODE_B, oc_b_ff, pc_mode, ~down_ff);
            end
            if (fast_mode && at_top) begin
                nxt_oc_a = fast_bottom(COMPARE_OUTPUT_MODE_A, nxt_oc_a);
                nxt_oc_b = fast_bottom(COMPARE_OUTPUT_MODE_B, nxt_oc_b);
            end
        end
        // Forced match touches the output only, never flag or counter
        if (!pwm_mode && FORCE_MATCH_STROBE_A) begin
            nxt_oc_a = cmp_action(COMPARE_OUTPUT_MODE_A, oc_a_ff, 1'b0, 1'b1);
        end
        if (!pwm_mode && FORCE_MATCH_STROBE_B) begin
            nxt_oc_b = cmp_action(COMPARE_OUTPUT_MODE_B, oc_b_ff, 1'b0, 1'b1);
        end
        if (COUNT_WR) begin
            nxt_count = COUNT_WDATA;
        end
    end

    // ************************************************
    // Counter, direction and match blocking
    // ************************************************
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            COUNT_VALUE <= `TMR8_BOTTOM;
            down_ff <= 1'b0;
            block_ff <= 1'b0;
        end else begin
            COUNT_VALUE <= nxt_count;
            down_ff <= nxt_down;
            if (COUNT_WR) begin
                block_ff <= 1'b1;
            end else if (timer_clock) begin
                block_ff <= 1'b0;
            end
        end
    end

    // ************************************************
    // Compare registers and their buffers
    // ************************************************
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            COMPARE_VALUE_A <= `TMR8_BOTTOM;
            COMPARE_VALUE_B <= `TMR8_BOTTOM;
            buf_a_ff <= `TMR8_BOTTOM;
            buf_b_ff <= `TMR8_BOTTOM;
        end else begin
            if (COMPARE_A_WR) begin
                buf_a_ff <= COMPARE_WDATA;
            end
            if (COMPARE_B_WR) begin
                buf_b_ff <= COMPARE_WDATA;
            end
            if (!pwm_mode) begin
                // Unbuffered: direct write, buffer tracks the active value
                if (COMPARE_A_WR) begin
                    COMPARE_VALUE_A <= COMPARE_WDATA;
                end
                if (COMPARE_B_WR) begin
                    COMPARE_VALUE_B <= COMPARE_WDATA;
                end
            end else if (load_buf) begin
                COMPARE_VALUE_A <= buf_a_ff;
                COMPARE_VALUE_B <= buf_b_ff;
            end
        end
    end

    // ************************************************
    // Flags, mask and interrupt request
    // ************************************************
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            TIMER_FLAG_REG <= 3'h0;
            TIMER_MASK_REG <= 3'h0;
            INT_REQ <= 1'b0;
        end else begin
            // Set wins over a clear in the same cycle
            TIMER_FLAG_REG <= (TIMER_FLAG_REG & ~(INT_ACK | ({3{FLAG_CLEAR_WR}} & FLAG_CLEAR_DATA)))
                | {timer_clock & match_b, timer_clock & match_a, ovf_evt};
            if (TIMER_MASK_WR) begin
                TIMER_MASK_REG <= TIMER_MASK_WDATA;
            end
            INT_REQ <= |(TIMER_FLAG_REG & TIMER_MASK_REG);
        end
    end

    // ************************************************
    // Output state bits and pin override
    // ************************************************
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            oc_a_ff <= 1'b0;
            oc_b_ff <= 1'b0;
            COMPARE_OUT_A <= 1'b0;
            COMPARE_OUT_B <= 1'b0;
            PIN_OUT_A <= 1'b0;
            PIN_OUT_B <= 1'b0;
            PIN_OE_A <= 1'b0;
            PIN_OE_B <= 1'b0;
            AT_BOTTOM <= 1'b1;
            AT_MAX <= 1'b0;
            AT_TOP <= 1'b0;
        end else begin
            oc_a_ff <= nxt_oc_a;
            oc_b_ff <= nxt_oc_b;
            COMPARE_OUT_A <= nxt_oc_a;
            COMPARE_OUT_B <= nxt_oc_b;
            // Mode fields act at once, in any waveform mode
            PIN_OUT_A <= (|COMPARE_OUTPUT_MODE_A) ? nxt_oc_a : PORT_VALUE_A;
            PIN_OUT_B <= (|COMPARE_OUTPUT_MODE_B) ? nxt_oc_b : PORT_VALUE_B;
            PIN_OE_A <= COMPARE_PIN_DIRECTION_A;
            PIN_OE_B <= COMPARE_PIN_DIRECTION_B;
            AT_BOTTOM <= (nxt_count == `TMR8_BOTTOM);
            AT_MAX <= (nxt_count == `TMR8_MAX);
            AT_TOP <= (nxt_count == top_val);
        end
    end
endmodule

// [tmr8_far_model.sv]
// Far-side model: prescaler tap pulses and external count input
`timescale 1ns/1ps
module tmr8_far_model (
    input wire clk,
    input wire rst,
    input wire [3:0] tap_req,
    input wire ext_req,
    output wire [3:0] taps,
    output wire ext
);
    reg [3:0] taps_ff;
    reg ext_ff;
    // ********
    // Drivers
    // ********
    // Taps pulse for one cycle; the external level toggles and holds for many cycles
    always @(posedge clk) begin
        if (rst) begin
            taps_ff <= 4'h0;
            ext_ff <= 1'b0;
        end else begin
            taps_ff <= tap_req;
            ext_ff <= ext_ff ^ ext_req;
        end
    end
    // Registered so every change lands just after an edge
    assign taps = taps_ff;
    assign ext = ext_ff;
endmodule

// [tmr8_sva.sv]
// Port-level checks for the dual compare timer
`timescale 1ns/1ps
module tmr8_sva (
    input wire SYS_CLK,
    input wire SYS_RST,
    input wire [2:0] CLOCK_SELECT,
    input wire [1:0] WAVEFORM_MODE_LO,
    input wire WAVEFORM_MODE_HI,
    input wire COUNT_WR,
    input wire [7:0] COUNT_WDATA,
    input wire [7:0] COUNT_VALUE,
    input wire [7:0] COMPARE_VALUE_A,
    input wire [2:0] TIMER_FLAG_REG,
    input wire [2:0] TIMER_MASK_REG,
    input wire INT_REQ,
    input wire AT_BOTTOM,
    input wire AT_MAX,
    input wire COMPARE_OUT_A,
    input wire COMPARE_PIN_DIRECTION_A,
    input wire PIN_OE_A
);
    // ********
    // Helpers
    // ********
    // Normal mode decode and masked interrupt source
    wire normal = {WAVEFORM_MODE_HI, WAVEFORM_MODE_LO} == 3'h0;
    wire int_src = |(TIMER_FLAG_REG & TIMER_MASK_REG);
    wire direct = CLOCK_SELECT == 3'h1;
    // Conservative copy of the match block; set at reset so no false firing
    reg blk_ff;
    wire nxt_blk = COUNT_WR | (blk_ff & ~direct);
    always @(posedge SYS_CLK) begin
        blk_ff <= SYS_RST | nxt_blk;
    end
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);
    // Live timer clock on an equal compare value
    sequence s_live_eq;
        !blk_ff && !COUNT_WR && direct && COUNT_VALUE == COMPARE_VALUE_A;
    endsequence
    // Counter write followed by a timer clock on an equal value
    sequence s_wr_eq;
        COUNT_WR ##1 (direct && !COUNT_WR && COUNT_VALUE == COMPARE_VALUE_A && !TIMER_FLAG_REG[1]);
    endsequence
    // ********
    // Properties
    // ********
    property p_ends;
        AT_BOTTOM == (COUNT_VALUE == 8'h00) && AT_MAX == (COUNT_VALUE == 8'hff);
    endproperty
    a_ends: assert property (p_ends) else $error("bottom or max level wrong");
    property p_stop;
        CLOCK_SELECT == 3'h0 && !COUNT_WR |=> COUNT_VALUE == $past(COUNT_VALUE);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved while stopped");
    property p_write;
        COUNT_WR |=> COUNT_VALUE == $past(COUNT_WDATA);
    endproperty
    a_write: assert property (p_write) else $error("counter write lost");
    property p_direct;
        normal && direct && !COUNT_WR |=> COUNT_VALUE == $past(COUNT_VALUE) + 8'h01;
    endproperty
    a_direct: assert property (p_direct) else $error("direct count step wrong");
    property p_ovf;
        normal && direct && !COUNT_WR && COUNT_VALUE == 8'hff |=> TIMER_FLAG_REG[0];
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag not set");
    property p_int;
        !$past(SYS_RST) |-> INT_REQ == $past(int_src);
    endproperty
    a_int: assert property (p_int) else $error("interrupt request not masked flags");
    property p_oe;
        !$past(SYS_RST) |-> PIN_OE_A == $past(COMPARE_PIN_DIRECTION_A);
    endproperty
    a_oe: assert property (p_oe) else $error("pin direction not followed");
    property p_match;
        s_live_eq |=> TIMER_FLAG_REG[1];
    endproperty
    a_match: assert property (p_match) else $error("compare flag missed");
    property p_block;
        s_wr_eq |=> !TIMER_FLAG_REG[1];
    endproperty
    a_block: assert property (p_block) else $error("match after write not blocked");
    property p_rst;
        $fell(SYS_RST) |-> !COMPARE_OUT_A;
    endproperty
    a_rst: assert property (p_rst) else $error("output state not cleared by reset");
endmodule
bind tmr8_dual_compare tmr8_sva tmr8_sva_inst (.SYS_CLK, .SYS_RST, .CLOCK_SELECT,
    .WAVEFORM_MODE_LO, .WAVEFORM_MODE_HI, .COUNT_WR, .COUNT_WDATA, .COUNT_VALUE,
    .COMPARE_VALUE_A, .TIMER_FLAG_REG, .TIMER_MASK_REG, .INT_REQ, .AT_BOTTOM, .AT_MAX,
    .COMPARE_OUT_A, .COMPARE_PIN_DIRECTION_A, .PIN_OE_A);

// [tmr8_tb_top.sv]
// Self-checking testbench for the dual compare timer
`timescale 1ns/1ps
module tb_top;
    // ********
    // Signals
    // ********
    reg clk, rst, wmh, fa, fb, cwr, awr, bwr, fcw, mwr, pva, pvb, dira, dirb, ext_req;
    reg [2:0] csel, fcd, ack, mwd;
    reg [1:0] wml, om_a, om_b;
    reg [7:0] cwd, cmpd;
    reg [3:0] tap_req;
    wire [7:0] cnt, cva, cvb;
    wire [2:0] flg, msk;
    wire [3:0] taps;
    wire irq, atb, atm, att, oca, ocb, pa, pb, oea, oeb, ext;
    integer fail_count, cmp_count, c, j, e;
    // Design and far side
    tmr8_dual_compare tmr8_dual_compare_inst (.SYS_CLK(clk), .SYS_RST(rst), .CLOCK_SELECT(csel),
        .WAVEFORM_MODE_LO(wml), .WAVEFORM_MODE_HI(wmh), .COMPARE_OUTPUT_MODE_A(om_a),
        .COMPARE_OUTPUT_MODE_B(om_b), .FORCE_MATCH_STROBE_A(fa), .FORCE_MATCH_STROBE_B(fb),
        .PRESC_TAP8(taps[0]), .PRESC_TAP64(taps[1]), .PRESC_TAP256(taps[2]),
        .PRESC_TAP1024(taps[3]), .EXTERNAL_COUNT_INPUT(ext), .COUNT_WR(cwr), .COUNT_WDATA(cwd),
        .COMPARE_A_WR(awr), .COMPARE_B_WR(bwr), .COMPARE_WDATA(cmpd), .FLAG_CLEAR_WR(fcw),
        .FLAG_CLEAR_DATA(fcd), .INT_ACK(ack), .TIMER_MASK_WR(mwr), .TIMER_MASK_WDATA(mwd),
        .PORT_VALUE_A(pva), .PORT_VALUE_B(pvb), .COMPARE_PIN_DIRECTION_A(dira),
        .COMPARE_PIN_DIRECTION_B(dirb), .COUNT_VALUE(cnt), .COMPARE_VALUE_A(cva),
        .COMPARE_VALUE_B(cvb), .TIMER_FLAG_REG(flg), .TIMER_MASK_REG(msk), .INT_REQ(irq),
        .AT_BOTTOM(atb), .AT_MAX(atm), .AT_TOP(att), .COMPARE_OUT_A(oca), .COMPARE_OUT_B(ocb),
        .PIN_OUT_A(pa), .PIN_OUT_B(pb), .PIN_OE_A(oea), .PIN_OE_B(oeb));
    tmr8_far_model tmr8_far_model_inst (.clk(clk), .rst(rst), .tap_req(tap_req),
        .ext_req(ext_req), .taps(taps), .ext(ext));
    // ********
    // Tasks
    // ********
    // Wait n edges, then step just past the edge
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // Compare and count
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // One-cycle counter write
    task wr_cnt(input [7:0] d);
        begin
            cwr = 1'b1;
            cwd = d;
            tick(1);
            cwr = 1'b0;
        end
    endtask
    // One-cycle write of both compare registers
    task wr_cmp(input [7:0] d);
        begin
            {awr, bwr} = 2'h3;
            cmpd = d;
            tick(1);
            {awr, bwr} = 2'h0;
        end
    endtask
    // Verdict and end of run
    task end_sim;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
            if (fail_count == 0 && cmp_count > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask
    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Watchdog
    initial begin
        #20000;
        fail_count = fail_count + 1;
        end_sim;
    end
    // ********
    // Tests
    // ********
    initial begin
        fail_count = 0;
        cmp_count = 0;
        {rst, wmh, fa, fb, cwr, awr, bwr, fcw, mwr, pva, pvb, dira, dirb, ext_req} = 14'h2000;
        {csel, fcd, ack, mwd, wml, om_a, om_b, cwd, cmpd, tap_req} = 38'h0;
        tick(4);
        rst = 1'b0;
        chk({atb, oca, ocb, flg, cnt}, 16'h2000);
        tick(5);
        chk(cnt, 8'h00);
        // Overflow and masked interrupt
        mwr = 1'b1;
        mwd = 3'h1;
        csel = 3'h1;
        tick(1);
        mwr = 1'b0;
        wr_cnt(8'hfd);
        chk({msk, cnt}, 16'h01fd);
        tick(3);
        chk({flg[0], cnt}, 16'h0100);
        csel = 3'h0;
        fcw = 1'b1;
        fcd = 3'h7;
        tick(1);
        fcw = 1'b0;
        chk({irq, flg}, 16'h0008);
        tick(1);
        chk(irq, 1'b0);
        // Compare matches, blocking and pin override
        wr_cmp(8'h10);
        chk({cva, cvb}, 16'h1010);
        om_a = 2'h1;
        {dira, dirb, pvb} = 3'h7;
        wr_cnt(8'h10);
        tick(3);
        csel = 3'h1;
        tick(1);
        chk({flg, cnt}, 16'h0011);
        wr_cnt(8'h10);
        tick(1);
        chk(flg, 3'h0);
        wr_cnt(8'h0e);
        tick(3);
        chk({flg, oca, ocb}, 5'h1a);
        csel = 3'h0;
        chk({pa, oea, pb, oeb}, 4'hf);
        ack = 3'h2;
        tick(1);
        ack = 3'h0;
        chk(flg, 3'h4);
        // Forced matches in normal mode
        om_a = 2'h2;
        om_b = 2'h3;
        {fa, fb} = 2'h3;
        tick(1);
        {fa, fb} = 2'h0;
        chk({oca, ocb, flg, cnt}, 13'h0c11);
        om_a = 2'h0;
        {pva, pvb} = 2'h2;
        tick(2);
        chk({pa, pb}, 2'h3);
        // Buffered compare in fast mode
        om_a = 2'h3;
        fa = 1'b1;
        tick(1);
        fa = 1'b0;
        wml = 2'h3;
        tick(1);
        chk(oca, 1'b1);
        om_a = 2'h1;
        fa = 1'b1;
        tick(1);
        fa = 1'b0;
        wr_cmp(8'h40);
        chk({oca, cva}, 9'h110);
        csel = 3'h1;
        wr_cnt(8'hfe);
        tick(1);
        chk({att, atm, cva}, 10'h310);
        tick(3);
        chk(cva, 8'h40);
        // Clear on compare with top from register A
        csel = 3'h0;
        wml = 2'h2;
        wr_cmp(8'h05);
        csel = 3'h1;
        wr_cnt(8'h04);
        tick(2);
        chk({cva, cnt}, 16'h0500);
        // Phase correct with top from register A, buffered compare
        csel = 3'h0;
        {wmh, wml, fcw, fcd} = 7'h5f;
        wr_cmp(8'h06);
        fcw = 1'b0;
        wr_cnt(8'h03);
        chk(cva, 8'h05);
        csel = 3'h1;
        tick(3);
        chk({cva, cnt}, 16'h0604);
        tick(4);
        chk(cnt, 8'h00);
        tick(1);
        chk({flg[0], cnt}, 16'h0101);
        csel = 3'h0;
        {wmh, wml} = 3'h0;
        // Prescaler taps and external edges
        for (c = 2; c < 8; c = c + 1) begin
            csel = c[2:0];
            wr_cnt(8'h00);
            e = 0;
            for (j = 0; j < 4; j = j + 1) begin
                tap_req = (c < 6) ? (4'h1 << j) : 4'h0;
                ext_req = (c > 5);
                tick(1);
                {tap_req, ext_req} = 5'h00;
                tick(5);
                e = e + ((c < 6) ? (j == c - 2) : ((j % 2 == 0) == (c == 7)));
                chk(cnt, e[15:0]);
            end
        end
        end_sim;
    end
endmodule
